// ==== hw/spi_eeprom_pkg.sv ====
// constants, types and opcodes shared by the serial memory slave and its bus master
//
// Behaviour
// - select low means selected and active
// - select high deselects; standby once write done
// - capture on rising, drive on falling, both polarities
// - pause starts on pause low with clock low
// - paused: output floats, clock and data ignored
// - pause ends on pause high with clock low
// - deselect while paused abandons the command
// - after power-up a falling select is needed; the synchroniser resets select high, so one held low through reset counts
// - write needs latch, whole bytes, data, boundary
// - select rising mid-byte discards a pending write
// - read data shifts out until select rises
// - status bits six to four read zero
// - busy flag set during internal write cycle
// - master polls busy flag until it clears
// - write instructions run only with latch set
// - latch set by command, cleared after writes
// - protect bits change only by unlocked status write
// - protect bits select the write-protected range
// - lock bit clear: status always writable
// - lock set and protect pin low: status frozen
// - frozen either order; only protect pin high exits
// - output most significant bit first, else floating

package spi_eeprom_pkg;

   // ==========================================================
   // instruction codes
   localparam logic [7:0] OP_SET_LATCH    = 8'h06;
   localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
   localparam logic [7:0] OP_STATUS_READ  = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
   localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
   localparam logic [7:0] OP_ID_READ      = 8'h83;
   localparam logic [7:0] OP_ID_WRITE     = 8'h82;

   // ==========================================================
   // status byte layout
   localparam int SR_BUSY_BIT = 0;
   localparam int SR_WEL_BIT  = 1;
   localparam int SR_BP_LSB   = 2;
   localparam int SR_LOCK_BIT = 7;
   localparam logic [1:0] BP_RESET   = 2'h0;
   localparam logic       LOCK_RESET = 1'b0;

   // ==========================================================
   // protected ranges
   localparam logic [1:0]  BP_NONE    = 2'h0;
   localparam logic [1:0]  BP_QUARTER = 2'h1;
   localparam logic [1:0]  BP_HALF    = 2'h2;
   localparam logic [13:0] PROT_QUARTER_BASE = 14'h3000;
   localparam logic [13:0] PROT_HALF_BASE    = 14'h2000;
   localparam int PAGE_BYTES = 64;

   // ==========================================================
   // timing
   localparam int PCLK_PERIOD_NS = 8;
   localparam int WRITE_CYCLE_NS = 4000000;
   localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_NS / PCLK_PERIOD_NS;
   localparam int SCK_PERIOD_NS = 64;
   localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * PCLK_PERIOD_NS);
   localparam logic [4:0] SCK_TOGGLES = 5'h10;

   // ==========================================================
   // controller registers (apb byte offsets) and control fields
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_TX     = 12'h004;
   localparam logic [11:0] REG_RX     = 12'h008;
   localparam logic [11:0] REG_STATUS = 12'h00C;
   localparam int CTRL_SELECT_BIT = 0;
   localparam int CTRL_CPOL_BIT   = 1;
   localparam int CTRL_HOLD_BIT   = 2;
   localparam int CTRL_WP_BIT     = 3;
   localparam logic [3:0] CTRL_RESET = 4'h8;

   // ==========================================================
   // command phase of the slave, gray along op, address, data
   typedef enum logic [2:0] {
      PH_OP      = 3'b000,
      PH_ADDR_HI = 3'b001,
      PH_ADDR_LO = 3'b011,
      PH_DATA    = 3'b010,
      PH_WAIT    = 3'b110
   } phase_t;

endpackage

// ==== hw/spi_link_if.sv ====
// serial link pins between the memory slave and its bus master
`timescale 1ns/1ps
`default_nettype none

interface spi_link_if;
   logic sck;
   logic ss_n;
   logic mosi;
   logic hold_n;
   logic wp_n;
   logic miso;
   logic miso_oe_n;

   modport dev (input sck, ss_n, mosi, hold_n, wp_n, output miso, miso_oe_n);
   modport ctl (output sck, ss_n, mosi, hold_n, wp_n, input miso, miso_oe_n);
endinterface // spi_link_if

`default_nettype wire

// ==== hw/spi_eeprom_dev.sv ====
// serial memory slave: protocol control, status register and write protection
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_dev #(
   parameter int unsigned WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLE_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   spi_link_if.dev          link,
   output logic [13:0]      mem_addr,
   output logic             mem_id,
   output logic             mem_we,
   output logic [7:0]       mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   output logic             write_busy_flag,
   output logic             standby,
   output logic             paused
);

   // ==========================================================
   // decode helpers
   function automatic logic is_write(input logic [7:0] op);
      is_write = (op == spi_eeprom_pkg::OP_ARRAY_WRITE) || (op == spi_eeprom_pkg::OP_ID_WRITE)
                 || (op == spi_eeprom_pkg::OP_STATUS_WRITE);
   endfunction

   function automatic logic is_read(input logic [7:0] op);
      is_read = (op == spi_eeprom_pkg::OP_ARRAY_READ) || (op == spi_eeprom_pkg::OP_ID_READ)
                || (op == spi_eeprom_pkg::OP_STATUS_READ);
   endfunction

   function automatic spi_eeprom_pkg::phase_t op_next(input logic [7:0] op,
                                                      input logic busy,
                                                      input logic write_enable_latch);
      case (op)
         spi_eeprom_pkg::OP_STATUS_READ:  op_next = spi_eeprom_pkg::PH_DATA;
         spi_eeprom_pkg::OP_STATUS_WRITE: op_next = (busy || !write_enable_latch) ? spi_eeprom_pkg::PH_WAIT
                                                                   : spi_eeprom_pkg::PH_DATA;
         spi_eeprom_pkg::OP_ARRAY_WRITE,
         spi_eeprom_pkg::OP_ID_WRITE:     op_next = (busy || !write_enable_latch) ? spi_eeprom_pkg::PH_WAIT
                                                                   : spi_eeprom_pkg::PH_ADDR_HI;
         spi_eeprom_pkg::OP_ARRAY_READ,
         spi_eeprom_pkg::OP_ID_READ:      op_next = busy ? spi_eeprom_pkg::PH_WAIT
                                                         : spi_eeprom_pkg::PH_ADDR_HI;
         default:                         op_next = spi_eeprom_pkg::PH_WAIT;
      endcase
   endfunction

   function automatic logic prot_hit(input logic [1:0] bp, input logic [13:0] a, input logic id);
      case (bp)
         spi_eeprom_pkg::BP_NONE:    prot_hit = 1'b0;
         spi_eeprom_pkg::BP_QUARTER: prot_hit = !id && (a >= spi_eeprom_pkg::PROT_QUARTER_BASE);
         spi_eeprom_pkg::BP_HALF:    prot_hit = !id && (a >= spi_eeprom_pkg::PROT_HALF_BASE);
         default:                    prot_hit = 1'b1;
      endcase
   endfunction

   // ==========================================================
   // pin synchronisers: sck, ss_n, mosi, hold_n, wp_n
   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   logic       sck_s;
   logic       ss_n_s;
   logic       mosi_s;
   logic       hold_n_s;
   logic       wp_n_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 5'h1F;
         pin_sync <= 5'h1F;
      end else begin
         pin_meta <= {link.sck, link.ss_n, link.mosi, link.hold_n, link.wp_n};
         pin_sync <= pin_meta;
      end
   end

   assign sck_s    = pin_sync[4];
   assign ss_n_s   = pin_sync[3];
   assign mosi_s   = pin_sync[2];
   assign hold_n_s = pin_sync[1];
   assign wp_n_s   = pin_sync[0];

   // ==========================================================
   // selection, pause and clock edges
   logic armed;
   logic selected;
   logic was_sel;
   logic end_frame;
   logic sck_prev;
   logic rise;
   logic fall;

   // armed sets once ss_n_s reads high, and the synchroniser resets it high, so a select low at power-up also counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         armed <= 1'b0;
      else if (ss_n_s)
         armed <= 1'b1;
   end

   assign selected  = armed && !ss_n_s;
   assign end_frame = was_sel && !selected;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         was_sel  <= 1'b0;
         sck_prev <= 1'b0;
      end else begin
         was_sel  <= selected;
         sck_prev <= sck_s;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         paused <= 1'b0;
      else if (!selected)
         paused <= 1'b0;
      else if (!paused && !hold_n_s && !sck_s)
         paused <= 1'b1;
      else if (paused && hold_n_s && !sck_s)
         paused <= 1'b0;
   end

   // sck_prev keeps tracking during a pause so no stale edge fires on resume
   assign rise = selected && !paused && sck_s && !sck_prev;
   assign fall = selected && !paused && !sck_s && sck_prev;

   // ==========================================================
   // command shifter and phase
   spi_eeprom_pkg::phase_t phase;
   logic [2:0]  bit_cnt;
   logic [7:0]  sh_in;
   logic [7:0]  in_byte;
   logic [7:0]  opcode;
   logic [15:0] addr;
   logic [7:0]  sr_data;
   logic        has_data;
   logic [63:0] wmask;
   logic [7:0]  wbuf [0:spi_eeprom_pkg::PAGE_BYTES-1];
   logic        write_enable_latch;
   logic        busy;
   logic [1:0]  bp;
   logic        lock;
   logic [7:0]  status;

   assign in_byte = {sh_in[6:0], mosi_s};
   assign status  = {lock, 3'h0, bp, write_enable_latch, busy};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase    <= spi_eeprom_pkg::PH_OP;
         bit_cnt  <= 3'h0;
         sh_in    <= 8'h00;
         opcode   <= 8'h00;
         addr     <= 16'h0000;
         sr_data  <= 8'h00;
         has_data <= 1'b0;
         wmask    <= 64'h0;
      end else if (end_frame) begin
         phase    <= spi_eeprom_pkg::PH_OP;
         bit_cnt  <= 3'h0;
         has_data <= 1'b0;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 3'h1;
         sh_in   <= in_byte;
         if (bit_cnt == 3'h7) begin
            case (phase)
               spi_eeprom_pkg::PH_OP: begin
                  opcode <= in_byte;
                  phase  <= op_next(in_byte, busy, write_enable_latch);
                  if (is_write(in_byte) && !busy && write_enable_latch)
                     wmask <= 64'h0;
               end
               spi_eeprom_pkg::PH_ADDR_HI: begin
                  addr[15:8] <= in_byte;
                  phase      <= spi_eeprom_pkg::PH_ADDR_LO;
               end
               spi_eeprom_pkg::PH_ADDR_LO: begin
                  addr[7:0] <= in_byte;
                  phase     <= spi_eeprom_pkg::PH_DATA;
               end
               spi_eeprom_pkg::PH_DATA: begin
                  if (opcode == spi_eeprom_pkg::OP_STATUS_WRITE) begin
                     if (!has_data)
                        sr_data <= in_byte;
                     has_data <= 1'b1;
                  end else if (is_write(opcode)) begin
                     wmask[addr[5:0]] <= 1'b1;
                     addr[5:0]        <= addr[5:0] + 6'h01; // page wraps
                     has_data         <= 1'b1;
                  end else if (opcode != spi_eeprom_pkg::OP_STATUS_READ) begin
                     addr[13:0] <= addr[13:0] + 14'h0001;
                  end
               end
               default: phase <= phase;
            endcase
         end
      end
   end

   // page buffer holds the bytes until the frame ends at a byte boundary
   always_ff @(posedge pclk) begin
      if (rise && bit_cnt == 3'h7 && phase == spi_eeprom_pkg::PH_DATA && is_write(opcode))
         wbuf[addr[5:0]] <= in_byte;
   end

   // ==========================================================
   // serial output
   logic [7:0] out_byte;
   logic [7:0] src_byte;
   logic       drive;

   always_comb begin
      if (bit_cnt != 3'h0)
         src_byte = out_byte;
      else if (opcode == spi_eeprom_pkg::OP_STATUS_READ)
         src_byte = status;
      else
         src_byte = mem_rdata;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive     <= 1'b0;
         out_byte  <= 8'h00;
         link.miso <= 1'b0;
      end else if (!selected) begin
         drive <= 1'b0;
      end else if (fall && phase == spi_eeprom_pkg::PH_DATA && is_read(opcode)) begin
         drive     <= 1'b1;
         out_byte  <= src_byte;
         link.miso <= src_byte[3'h7 - bit_cnt];
      end
   end

   assign link.miso_oe_n = !(drive && !paused);

   // ==========================================================
   // frame completion, latch, status and internal write cycle
   logic        frame_ok;
   logic        sr_open;
   logic        pend_sr;
   logic [7:0]  wpage;
   logic        wr_id;
   logic [31:0] wc_cnt;

   assign frame_ok = phase == spi_eeprom_pkg::PH_DATA && bit_cnt == 3'h0 && has_data
                     && is_write(opcode);
   assign sr_open  = !lock || wp_n_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_enable_latch     <= 1'b0;
         busy    <= 1'b0;
         bp      <= spi_eeprom_pkg::BP_RESET;
         lock    <= spi_eeprom_pkg::LOCK_RESET;
         pend_sr <= 1'b0;
         wpage   <= 8'h00;
         wr_id   <= 1'b0;
         wc_cnt  <= 32'h0;
      end else if (busy) begin
         wc_cnt <= wc_cnt + 32'h1;
         if (end_frame && bit_cnt == 3'h0 && phase == spi_eeprom_pkg::PH_WAIT
             && opcode == spi_eeprom_pkg::OP_CLEAR_LATCH)
            write_enable_latch <= 1'b0;
         if (wc_cnt == WRITE_CYCLES - 32'h1) begin
            busy <= 1'b0;
            write_enable_latch  <= 1'b0;
            if (pend_sr) begin
               lock <= sr_data[spi_eeprom_pkg::SR_LOCK_BIT];
               bp   <= sr_data[spi_eeprom_pkg::SR_BP_LSB +: 2];
            end
         end
      end else if (end_frame && bit_cnt == 3'h0 && phase == spi_eeprom_pkg::PH_WAIT) begin
         if (opcode == spi_eeprom_pkg::OP_SET_LATCH)
            write_enable_latch <= 1'b1;
         else if (opcode == spi_eeprom_pkg::OP_CLEAR_LATCH)
            write_enable_latch <= 1'b0;
      end else if (end_frame && frame_ok) begin
         pend_sr <= opcode == spi_eeprom_pkg::OP_STATUS_WRITE;
         wpage   <= addr[13:6];
         wr_id   <= opcode[7];
         wc_cnt  <= 32'h0;
         if (opcode == spi_eeprom_pkg::OP_STATUS_WRITE)
            busy <= sr_open;
         else
            busy <= !prot_hit(bp, addr[13:0], opcode[7]);
      end
   end

   // buffered bytes go to the array during the first cycles of the write cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr  <= 14'h0000;
         mem_id    <= 1'b0;
         mem_we    <= 1'b0;
         mem_wdata <= 8'h00;
      end else if (busy && !pend_sr && wc_cnt < spi_eeprom_pkg::PAGE_BYTES) begin
         mem_addr  <= {wpage, wc_cnt[5:0]};
         mem_id    <= wr_id;
         mem_we    <= wmask[wc_cnt[5:0]];
         mem_wdata <= wbuf[wc_cnt[5:0]];
      end else begin
         mem_addr <= addr[13:0];
         mem_id   <= opcode[7];
         mem_we   <= 1'b0;
      end
   end

   assign write_busy_flag = busy;
   assign standby         = !selected && !busy;

endmodule // spi_eeprom_dev

`default_nettype wire

// ==== hw/spi_eeprom_ctl.sv ====
// bus master for the serial memory: apb registers drive the link byte by byte
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_ctl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   spi_link_if.ctl          link
);

   // ==========================================================
   // apb slave, zero wait states
   logic [3:0] ctrl;
   logic [7:0] tx_sh;
   logic [7:0] rx;
   logic       busy;
   logic       mapped;
   logic       wr_acc;
   logic       start;

   assign mapped  = paddr == spi_eeprom_pkg::REG_CTRL || paddr == spi_eeprom_pkg::REG_TX
                    || paddr == spi_eeprom_pkg::REG_RX || paddr == spi_eeprom_pkg::REG_STATUS;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign wr_acc  = psel && penable && pwrite && mapped;
   // a byte written while one is in flight is dropped; software polls busy first
   assign start   = wr_acc && paddr == spi_eeprom_pkg::REG_TX && !busy;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0;
      else if (psel && !penable) begin
         case (paddr)
            spi_eeprom_pkg::REG_CTRL:   prdata <= {28'h0, ctrl};
            spi_eeprom_pkg::REG_RX:     prdata <= {24'h0, rx};
            spi_eeprom_pkg::REG_STATUS: prdata <= {30'h0, !link.hold_n, busy};
            default:                    prdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl <= spi_eeprom_pkg::CTRL_RESET;
      else if (wr_acc && paddr == spi_eeprom_pkg::REG_CTRL)
         ctrl <= pwdata[3:0];
   end

   assign link.ss_n = !ctrl[spi_eeprom_pkg::CTRL_SELECT_BIT];
   assign link.wp_n = ctrl[spi_eeprom_pkg::CTRL_WP_BIT];

   // ==========================================================
   // returning data pin synchroniser
   logic miso_meta;
   logic miso_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miso_meta <= 1'b0;
         miso_s    <= 1'b0;
      end else begin
         miso_meta <= link.miso;
         miso_s    <= miso_meta;
      end
   end

   // ==========================================================
   // pause only lowers while the clock is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         link.hold_n <= 1'b1;
      else if (!ctrl[spi_eeprom_pkg::CTRL_HOLD_BIT])
         link.hold_n <= 1'b1;
      else if (!link.sck)
         link.hold_n <= 1'b0;
   end

   // ==========================================================
   // byte engine: 16 clock toggles, returning data taken half a period after
   // each rising edge, which leaves room for both synchronisers
   logic [2:0] div;
   logic [4:0] tog;
   logic       tick;
   logic       was_rise;

   assign tick     = busy && link.hold_n && div == 3'(spi_eeprom_pkg::SCK_HALF_CYCLES - 1);
   assign was_rise = tog != 5'h0 && (tog[0] != ctrl[spi_eeprom_pkg::CTRL_CPOL_BIT]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         div <= 3'h0;
      else if (!busy || tick)
         div <= 3'h0;
      else if (link.hold_n)
         div <= div + 3'h1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy      <= 1'b0;
         tog       <= 5'h0;
         tx_sh     <= 8'h00;
         rx        <= 8'h00;
         link.sck  <= 1'b0;
         link.mosi <= 1'b0;
      end else if (start) begin
         busy      <= 1'b1;
         tog       <= 5'h0;
         tx_sh     <= pwdata[7:0];
         link.mosi <= pwdata[7];
         link.sck  <= ctrl[spi_eeprom_pkg::CTRL_CPOL_BIT];
      end else if (!busy) begin
         link.sck <= ctrl[spi_eeprom_pkg::CTRL_CPOL_BIT];
      end else if (tick) begin
         if (was_rise) begin
            rx        <= {rx[6:0], miso_s};
            tx_sh     <= {tx_sh[6:0], 1'b0};
            link.mosi <= tx_sh[6];
         end
         if (tog == spi_eeprom_pkg::SCK_TOGGLES)
            busy <= 1'b0;
         else begin
            link.sck <= !link.sck;
            tog      <= tog + 5'h1;
         end
      end
   end

endmodule // spi_eeprom_ctl

`default_nettype wire

// ==== bench/spi_eeprom_asserts.sv ====
// concurrent checks on the serial link between memory slave and bus master
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sck,
   input wire logic ss_n,
   input wire logic hold_n,
   input wire logic miso,
   input wire logic miso_oe_n,
   input wire logic write_busy_flag,
   input wire logic standby,
   input wire logic paused
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // select, pause and output rules
   a_sel_active: assert property (!ss_n [*5] |-> !standby)
      else $error("standby while selected");
   a_busy_no_standby: assert property (write_busy_flag |-> !standby)
      else $error("standby during write cycle");
   a_idle_standby: assert property (ss_n [*6] ##0 !write_busy_flag |-> standby)
      else $error("no standby while idle");
   // pins reach the pause flag through two sync flops, so the cause lies three samples back
   a_pause_entry: assert property ($rose(paused) |-> $past(!hold_n, 3) && $past(!sck, 3))
      else $error("pause without pause pin low and clock low");
   a_pause_float: assert property (paused |-> miso_oe_n)
      else $error("output driven while paused");
   // a deselect also ends a pause, whatever the pause pin does
   a_pause_exit: assert property ($fell(paused) && !$past(ss_n, 3)
                                  |-> $past(hold_n, 3) && $past(!sck, 3))
      else $error("pause left without pause pin high");
   a_desel_float: assert property (ss_n [*6] |-> miso_oe_n)
      else $error("output driven while deselected");
   a_out_on_low: assert property (!miso_oe_n && $changed(miso) |-> !$past(sck))
      else $error("output changed outside low clock phase");
endmodule // spi_eeprom_asserts

`default_nettype wire

// ==== bench/spi_eeprom_protocol_protect_test.sv ====
// self-checking bench: apb master drives the link into the memory slave
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_protocol_protect_test;
   typedef logic [7:0] bq_t[$];
   logic        pclk = 0;
   logic        presetn = 0;
   logic [11:0] paddr = '0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, r, a, d;
   logic        pready, pslverr, slverr, mem_we, mem_id, busy, standby, paused;
   logic        wp = 1, hold = 0, cpol = 0;
   logic [13:0] mem_addr, wa;
   logic [7:0]  mem_wdata, mem_rdata, wd, x;
   logic [31:0] seed = 32'h19;
   int          num_errors = 0, comparisons = 0, cyc = 0;
   spi_link_if link ();
   spi_eeprom_ctl spi_eeprom_ctl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link));
   spi_eeprom_dev #(.WRITE_CYCLES(100)) spi_eeprom_dev_inst (.pclk(pclk), .presetn(presetn),
      .link(link), .mem_addr(mem_addr), .mem_id(mem_id), .mem_we(mem_we), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .write_busy_flag(busy), .standby(standby), .paused(paused));
   spi_eeprom_asserts spi_eeprom_asserts_inst (.pclk(pclk), .presetn(presetn), .sck(link.sck),
      .ss_n(link.ss_n), .hold_n(link.hold_n), .miso(link.miso), .miso_oe_n(link.miso_oe_n),
      .write_busy_flag(busy), .standby(standby), .paused(paused));
   // ==========================================================
   // array model: read data is a known pattern, last write is kept
   assign mem_rdata = mem_addr[7:0] ^ (mem_id ? 8'hA5 : 8'h5A);
   always @(posedge pclk) if (mem_we) begin
      wa <= mem_addr;
      wd <= mem_wdata;
   end
   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         wrap_up();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] dt);
      @(posedge pclk);
      {paddr, pwrite, pwdata, psel, penable} <= {ad, w, dt, 2'b10};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      slverr = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic cfg(input logic s);
      apb(spi_eeprom_pkg::REG_CTRL, 1, {28'h0, wp, hold, cpol, s});
      // slave needs select seen high through its synchronizer
      if (!s) repeat (6) @(posedge pclk);
   endtask
   task automatic xb(input logic [7:0] b);
      apb(spi_eeprom_pkg::REG_TX, 1, {24'h0, b});
      do apb(spi_eeprom_pkg::REG_STATUS, 0, 0); while (r[0] !== 1'b0);
      apb(spi_eeprom_pkg::REG_RX, 0, 0);
      x = r[7:0];
   endtask
   task automatic frame(input bq_t q);
      cfg(1);
      foreach (q[i]) xb(q[i]);
      cfg(0);
   endtask
   task automatic status_read_cmd();
      frame('{spi_eeprom_pkg::OP_STATUS_READ, 8'h00});
   endtask
   task automatic wcmd(input bq_t q, input logic e);
      frame('{spi_eeprom_pkg::OP_SET_LATCH});
      frame(q);
      chk(busy, e);
      status_read_cmd();
      if (e) chk(x[0], 1);
      while (x[0] !== 1'b0) status_read_cmd();
   endtask
   task automatic wrap_up();
      if (num_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      apb(12'h010, 0, 32'hFFFFFFFF);
      chk(slverr, 1);
      chk(r[15:0], 0);
      status_read_cmd();
      chk(x, 8'h00);
      chk(slverr, 0);
      frame('{spi_eeprom_pkg::OP_SET_LATCH});
      status_read_cmd();
      chk(x, 8'h02);
      frame('{spi_eeprom_pkg::OP_CLEAR_LATCH});
      status_read_cmd();
      chk(x, 8'h00);
      a = rnd();
      d = rnd();
      frame('{spi_eeprom_pkg::OP_ARRAY_WRITE, a[15:8], a[7:0], d[7:0]});
      chk(busy, 0);
      wcmd('{spi_eeprom_pkg::OP_ARRAY_WRITE, a[15:8], a[7:0], d[7:0]}, 1);
      chk({wa, wd}, {a[13:0], d[7:0]});
      chk(x, 8'h00);
      // deselect in the middle of the second data byte
      frame('{spi_eeprom_pkg::OP_SET_LATCH});
      cfg(1);
      xb(spi_eeprom_pkg::OP_ARRAY_WRITE);
      xb(8'h00);
      xb(8'h00);
      xb(d[7:0]);
      apb(spi_eeprom_pkg::REG_TX, 1, 32'hA5);
      repeat (20) @(posedge pclk);
      cfg(0);
      repeat (80) @(posedge pclk);
      chk(busy, 0);
      wcmd('{spi_eeprom_pkg::OP_STATUS_WRITE, 8'h84}, 1);
      chk(x, 8'h84);
      wcmd('{spi_eeprom_pkg::OP_ARRAY_WRITE, 8'h30 | a[11:8], a[7:0], d[7:0]}, 0);
      wcmd('{spi_eeprom_pkg::OP_ARRAY_WRITE, a[15:8] & 8'h2F, a[7:0], d[7:0]}, 1);
      wp = 0;
      wcmd('{spi_eeprom_pkg::OP_STATUS_WRITE, 8'h00}, 0);
      chk(x, 8'h86);
      wp = 1;
      wcmd('{spi_eeprom_pkg::OP_STATUS_WRITE, 8'h00}, 1);
      chk(x, 8'h00);
      wp = 0;
      wcmd('{spi_eeprom_pkg::OP_STATUS_WRITE, 8'h08}, 1);
      chk(x, 8'h08);
      wp = 1;
      wcmd('{spi_eeprom_pkg::OP_STATUS_WRITE, 8'h00}, 1);
      for (int c = 0; c < 2; c++) begin
         cpol = c[0];
         cfg(0);
         a = rnd();
         cfg(1);
         xb(c[0] ? spi_eeprom_pkg::OP_ID_READ : spi_eeprom_pkg::OP_ARRAY_READ);
         xb(a[15:8]);
         xb(a[7:0]);
         xb(8'h00);
         chk(x, a[7:0] ^ (c[0] ? 8'hA5 : 8'h5A));
         // idle clock is high with cpol set, so pause would never engage
         if (c == 0) begin
            hold = 1;
            cfg(1);
            repeat (12) @(posedge pclk);
            chk({paused, link.miso_oe_n}, 2'b11);
            hold = 0;
            cfg(1);
            repeat (12) @(posedge pclk);
            chk(paused, 0);
         end
         xb(8'h00);
         chk(x, (a[7:0] + 8'h01) ^ (c[0] ? 8'hA5 : 8'h5A));
         cfg(0);
      end
      // deselect while paused ends the pause; a reset clears the latch
      cpol = 0;
      cfg(0);
      hold = 1;
      cfg(1);
      repeat (12) @(posedge pclk);
      chk(paused, 1);
      cfg(0);
      chk(paused, 0);
      hold = 0;
      cfg(0);
      frame('{spi_eeprom_pkg::OP_SET_LATCH});
      presetn <= 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      status_read_cmd();
      chk(x, 8'h00);
      chk(standby, 1);
      wrap_up();
   end
endmodule // spi_eeprom_protocol_protect_test

`default_nettype wire
